// >>> shared/afp_defs.svh
`ifndef AFP_DEFS_SVH
`define AFP_DEFS_SVH
// ==========================================================
// timing and channel count
`define AFP_CLK_PERIOD_NS 8
`define AFP_LIMIT_TIME_US 1700
`define AFP_LIMIT_CYCLES ((`AFP_LIMIT_TIME_US * 1000) / `AFP_CLK_PERIOD_NS)
`define AFP_RAMP_CYCLES 256
`define AFP_CH_COUNT 4
`endif

// >>> shared/afp_pkg.sv
package afp_pkg;
   // ==========================================================
   // types
   typedef enum logic [1:0] {AFP_RUN, AFP_RAMP, AFP_HOLD} afp_rst_e;
   typedef struct packed {
      logic temp_warning;
      logic temp_shutdown;
      logic power_stage_uv;
      logic gate_drive_uv;
      logic analog_uv;
      logic digital_por;
      logic clock_lost;
   } afp_global_s;
   typedef struct packed {
      logic hiz;
      logic switch_en;
      logic high_side_en;
      logic pull_down;
      logic weak_pull_down;
   } afp_bridge_s;
endpackage

// >>> hw/afp_fault_ctrl.sv
// Function
// [RULE1] drive warning low while temperature above warning level; keep switching
// [RULE2] over shutdown level: all outputs high impedance, fault low, latched
// [RULE3] thermal shutdown latch cleared only by reset; then normal operation
// [RULE4] power-on clear resets overload logic; hold off until supplies valid
// [RULE5] any supply undervoltage forces high impedance and fault low at once
// [RULE6] supplies recovered: resume automatically without reset
// [RULE7] global fault stops switching on every channel, fault low
// [RULE8] channel fault stops only affected channels; others keep running
// [RULE9] reset low forces fault output high
// [RULE10] controller releases reset only while warning reads high
// [RULE11] supply and power-on faults are global, reported, self clearing
// [RULE12] bootstrap undervoltage turns off only that high side, unreported
// [RULE13] warning only on warning output, clears itself below threshold
// [RULE14] current limiting beyond limit time latches channel off, reports fault
// [RULE15] slave clock lost: high impedance unreported, recovers by itself
// [RULE16] reset low starts ramp-down; high impedance only after it completes
// [RULE17] reset low enables pull-downs; weak ones in bridge-tied mode
// [RULE18] reset rising edge resumes after latched overload
// [RULE19] controller waits the stated delay after fault fall before raising reset
// [RULE20] fault/warning encode normal, warning, overload or undervoltage
// [RULE21] detector inputs synchronized; decisions made on clock edges
`timescale 1ns/100ps
`default_nettype none
`include "afp_defs.svh"
module afp_fault_ctrl #(
   parameter int CH = `AFP_CH_COUNT,
   parameter int LIMIT_CYCLES = `AFP_LIMIT_CYCLES,
   parameter int RAMP_CYCLES = `AFP_RAMP_CYCLES
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic i_ce,
   input wire logic i_reset_n,
   input wire logic i_bridge_tied_mode,
   input wire logic i_slave_mode,
   input wire afp_pkg::afp_global_s i_det,
   input wire logic [CH-1:0] i_cycle_current_limit,
   input wire logic [CH-1:0] i_bootstrap_uv,
   output logic o_fault_n,
   output logic o_clip_temp_warning_n,
   output logic o_ramp_active,
   output afp_pkg::afp_bridge_s [CH-1:0] o_bridge
);
   import afp_pkg::*;

   // ==========================================================
   // synchronisers
   localparam int GW = $bits(afp_global_s);
   logic [GW-1:0] g_s1, g_s2;
   logic [CH-1:0] cl_s1, cl_s2, bs_s1, bs_s2;
   logic rst_s1, rst_s2, rst_d;
   afp_global_s det;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         g_s1 <= '0;
         g_s2 <= '0;
         cl_s1 <= '0;
         cl_s2 <= '0;
         bs_s1 <= '0;
         bs_s2 <= '0;
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         rst_d <= 1'b0;
      end else if (i_ce) begin
         g_s1 <= i_det; // [RULE21]
         g_s2 <= g_s1;
         cl_s1 <= i_cycle_current_limit;
         cl_s2 <= cl_s1;
         bs_s1 <= i_bootstrap_uv;
         bs_s2 <= bs_s1;
         rst_s1 <= i_reset_n;
         rst_s2 <= rst_s1;
         rst_d <= rst_s2;
      end
   end
   assign det = afp_global_s'(g_s2);

   logic rst_rise;
   assign rst_rise = rst_s2 && !rst_d; // [RULE18]

   // ==========================================================
   // supply faults, self clearing
   logic supply_fault;
   assign supply_fault = det.power_stage_uv | det.gate_drive_uv | det.analog_uv
                         | det.digital_por; // [RULE5] [RULE6] [RULE11]

   // ==========================================================
   // thermal shutdown latch
   logic thermal_shutdown_latch;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         thermal_shutdown_latch <= 1'b0;
      end else if (i_ce) begin
         if (det.temp_shutdown) begin
            thermal_shutdown_latch <= 1'b1; // [RULE2]
         end else if (!rst_s2) begin
            thermal_shutdown_latch <= 1'b0; // [RULE3]
         end
      end
   end

   // ==========================================================
   // overload guard per channel
   localparam int CW = $clog2(LIMIT_CYCLES + 1);
   logic [CH-1:0] overload_guard;
   genvar g;
   generate
      for (g = 0; g < CH; g++) begin : g_ch
         logic [CW-1:0] cnt;
         always_ff @(posedge I_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               cnt <= '0;
            end else if (i_ce) begin
               // power-on clear holds the counter idle
               if (det.digital_por || !cl_s2[g]) begin
                  cnt <= '0; // [RULE4]
               end else if (cnt != CW'(LIMIT_CYCLES)) begin
                  cnt <= cnt + 1'b1;
               end
            end
         end
         always_ff @(posedge I_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               overload_guard[g] <= 1'b0;
            end else if (i_ce) begin
               if (cnt == CW'(LIMIT_CYCLES)) begin
                  overload_guard[g] <= 1'b1; // [RULE14]
               end else if (det.digital_por || rst_rise) begin
                  overload_guard[g] <= 1'b0; // [RULE4] [RULE18]
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // reset ramp-down sequence
   localparam int RW = $clog2(RAMP_CYCLES + 1);
   afp_rst_e rst_state;
   logic [RW-1:0] ramp_cnt;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rst_state <= AFP_HOLD;
         ramp_cnt <= '0;
      end else if (i_ce) begin
         unique case (rst_state)
            AFP_RUN: begin
               if (!rst_s2) begin
                  rst_state <= AFP_RAMP; // [RULE16]
                  ramp_cnt <= '0;
               end
            end
            AFP_RAMP: begin
               if (ramp_cnt == RW'(RAMP_CYCLES - 1)) begin
                  rst_state <= AFP_HOLD;
               end else begin
                  ramp_cnt <= ramp_cnt + 1'b1;
               end
            end
            AFP_HOLD: begin
               if (rst_s2) begin
                  rst_state <= AFP_RUN;
               end
            end
         endcase
      end
   end
   assign o_ramp_active = (rst_state == AFP_RAMP);

   // ==========================================================
   // output decisions
   logic global_off, reported, held;
   // clock loss is silent and clears itself; only meaningful in slave mode
   assign global_off = supply_fault | thermal_shutdown_latch
                       | (i_slave_mode & det.clock_lost); // [RULE7] [RULE15]
   assign reported = supply_fault | thermal_shutdown_latch | (|overload_guard); // [RULE20]
   assign held = (rst_state == AFP_HOLD);

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         o_fault_n <= 1'b1;
         o_clip_temp_warning_n <= 1'b1;
      end else if (i_ce) begin
         // stays high on the release edge: a clearing overload is not yet visible there
         o_fault_n <= (!rst_s2 || rst_rise) ? 1'b1 : !reported; // [RULE9] [RULE18] [RULE20]
         o_clip_temp_warning_n <= !det.temp_warning; // [RULE1] [RULE13]
      end
   end

   generate
      for (g = 0; g < CH; g++) begin : g_out
         always_ff @(posedge I_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
               o_bridge[g] <= '{hiz: 1'b1, switch_en: 1'b0, high_side_en: 1'b0,
                                pull_down: 1'b0, weak_pull_down: 1'b0};
            end else if (i_ce) begin
               o_bridge[g].hiz <= global_off | overload_guard[g] | held; // [RULE2] [RULE8] [RULE16]
               o_bridge[g].switch_en <= !(global_off | overload_guard[g] | held); // [RULE8]
               o_bridge[g].high_side_en <= !(global_off | overload_guard[g] | held)
                                           & !bs_s2[g]; // [RULE12]
               o_bridge[g].pull_down <= !rst_s2 & !i_bridge_tied_mode; // [RULE17]
               o_bridge[g].weak_pull_down <= !rst_s2 & i_bridge_tied_mode; // [RULE17]
            end
         end
      end
   endgenerate

   // ==========================================================
   // checks
   // an inner channel is watched besides channel 0
   localparam int WCH = CH / 2;

   sequence s_reset_low;
      !rst_s2;
   endsequence

   sequence s_ramp_done;
      rst_state == AFP_HOLD;
   endsequence

   sequence s_hot;
      det.temp_shutdown;
   endsequence

   sequence s_overload_full;
      g_ch[WCH].cnt == CW'(LIMIT_CYCLES);
   endsequence

   sequence s_clock_lost;
      i_slave_mode && det.clock_lost;
   endsequence

   // ==========================================================
   // reset pin and ramp-down
   a_fault_forced_high: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE9]
      (i_ce and s_reset_low) |=> o_fault_n)
      else $error("fault low while reset held");

   a_ramp_before_hiz: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE16]
      ((i_ce && rst_state == AFP_RUN) and s_reset_low) |=> (rst_state == AFP_RAMP))
      else $error("ramp-down skipped");

   a_ramp_length: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE16]
      (i_ce && $rose(o_ramp_active)) |-> ##[1:1000] (!i_ce or s_ramp_done))
      else $error("ramp-down did not complete");

   a_hold_hiz: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE16]
      (i_ce and s_ramp_done) |=> o_bridge[0].hiz)
      else $error("outputs not high impedance after ramp-down");

   a_pulldown_mode: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE17]
      (i_ce and s_reset_low) |=> (o_bridge[0].pull_down || o_bridge[0].weak_pull_down))
      else $error("no pull-down during reset");

   a_weak_pull_btl: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE17]
      ((i_ce && i_bridge_tied_mode) and s_reset_low)
      |=> (o_bridge[0].weak_pull_down && !o_bridge[0].pull_down))
      else $error("bridge-tied mode without weak pull-down");

   // ==========================================================
   // temperature
   a_warning_follows_temp: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE1]
      i_ce |=> (o_clip_temp_warning_n == !$past(det.temp_warning)))
      else $error("warning output wrong");

   a_warn_no_stop: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE1]
      (i_ce && det.temp_warning && !global_off && !held && !overload_guard[0])
      |=> o_bridge[0].switch_en)
      else $error("warning stopped switching");

   a_shutdown_latch: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE2]
      (i_ce and s_hot) |=> thermal_shutdown_latch)
      else $error("thermal shutdown not latched");

   a_shutdown_hiz: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE2]
      (i_ce && thermal_shutdown_latch) |=> (o_bridge[0].hiz && o_bridge[CH-1].hiz))
      else $error("thermal shutdown left outputs driven");

   a_shutdown_fault: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE2]
      (i_ce && thermal_shutdown_latch && rst_s2 && !rst_rise) |=> !o_fault_n)
      else $error("thermal shutdown not reported");

   a_thermal_latch_holds: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE3]
      (i_ce && thermal_shutdown_latch && rst_s2) |=> thermal_shutdown_latch)
      else $error("thermal latch cleared without reset");

   // ==========================================================
   // supplies and switching clock
   a_supply_hiz: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE5]
      (i_ce && supply_fault)
      |=> (o_bridge[0].hiz && (!$past(rst_s2) || $past(rst_rise) || !o_fault_n)))
      else $error("undervoltage not acted on");

   a_supply_resume: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE6]
      (i_ce && !global_off && !overload_guard[0] && !held) |=> !o_bridge[0].hiz)
      else $error("outputs did not resume");

   a_global_all_off: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE7]
      (i_ce && global_off) |=> (!o_bridge[0].switch_en && !o_bridge[CH-1].switch_en))
      else $error("global fault left a channel switching");

   a_clock_lost_hiz: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE15]
      (i_ce and s_clock_lost) |=> o_bridge[0].hiz)
      else $error("lost switching clock left outputs driven");

   a_quiet_fault_high: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE15]
      (i_ce && rst_s2 && !reported) |=> o_fault_n)
      else $error("fault reported without a reported cause");

   a_sync_delay: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE21]
      ($past(i_ce) && $past(i_ce, 2)) |-> (g_s2 == $past(i_det, 2)))
      else $error("detector synchroniser delay wrong");

   // ==========================================================
   // channel faults
   a_overload_sets: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE14]
      (i_ce and s_overload_full) |=> overload_guard[WCH])
      else $error("persistent current limit not latched");

   a_overload_latch: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE14]
      (i_ce && overload_guard[WCH] && !rst_rise && !det.digital_por) |=> overload_guard[WCH])
      else $error("overload cleared without reset edge");

   a_overload_reported: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE14]
      (i_ce && overload_guard[WCH] && rst_s2 && !rst_rise) |=> !o_fault_n)
      else $error("overload not reported");

   a_por_clears: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE4]
      (i_ce && det.digital_por && g_ch[WCH].cnt != CW'(LIMIT_CYCLES)) |=> !overload_guard[WCH])
      else $error("power-on clear left overload set");

   a_reset_rise_clears: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE18]
      (i_ce && rst_rise && g_ch[WCH].cnt != CW'(LIMIT_CYCLES)) |=> !overload_guard[WCH])
      else $error("reset edge left overload set");

   a_channel_only: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE8]
      (i_ce && overload_guard[WCH] && !overload_guard[0] && !global_off && !held)
      |=> (!o_bridge[WCH].switch_en && o_bridge[0].switch_en))
      else $error("channel fault spread to other channels");

   a_bootstrap_hs: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE12]
      (i_ce && bs_s2[WCH]) |=> !o_bridge[WCH].high_side_en)
      else $error("high side on during bootstrap undervoltage");

   a_bootstrap_other: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // [RULE12]
      (i_ce && !bs_s2[0] && !global_off && !held && !overload_guard[0])
      |=> o_bridge[0].high_side_en)
      else $error("high side off without bootstrap undervoltage");
endmodule // afp_fault_ctrl
`default_nettype wire

// >>> testbench/afp_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// controller that watches the fault pins and drives the reset pin
module afp_mcu_model #(
   parameter int DELAY = 16
) (
   input wire logic I_CLK,
   input wire logic i_fault_n,
   input wire logic i_warn_n,
   input wire logic i_run,
   output logic o_reset_n
);
   int cnt = DELAY;
   logic fault_q = 1'b1;
   initial o_reset_n = 1'b0;
   // a fault fall restarts the cool-down count before reset may rise
   always @(negedge I_CLK) begin
      fault_q <= i_fault_n;
      if (fault_q && !i_fault_n) cnt <= 0;
      else if (cnt < DELAY) cnt <= cnt + 1;
      if (!i_run) o_reset_n <= 1'b0;
      else if (i_warn_n && cnt >= DELAY) o_reset_n <= 1'b1;
   end
endmodule // afp_mcu_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   import afp_pkg::*;
   localparam int CH = 4;
   localparam int LIM = 20;
   localparam int RAMP = 8;
   logic clk = 1'b0, rst_b = 1'b0, run = 1'b1, bridge_tied_mode = 1'b1, slave = 1'b0;
   logic rst_n, fault_n, warn_n, ramp;
   logic ce = 1'b1;
   afp_global_s det = '0;
   logic [CH-1:0] lim = '0, bst = '0;
   afp_bridge_s [CH-1:0] br;
   int bad_count = 0;
   int checks_done = 0;
   always #4 clk = ~clk;
   afp_mcu_model #(.DELAY(16)) i_mcu (.I_CLK(clk), .i_fault_n(fault_n), .i_warn_n(warn_n),
      .i_run(run), .o_reset_n(rst_n));
   afp_fault_ctrl #(.CH(CH), .LIMIT_CYCLES(LIM), .RAMP_CYCLES(RAMP)) i_dut (.I_CLK(clk),
      .I_RST_B(rst_b), .i_ce(ce), .i_reset_n(rst_n), .i_bridge_tied_mode(bridge_tied_mode),
      .i_slave_mode(slave), .i_det(det), .i_cycle_current_limit(lim), .i_bootstrap_uv(bst),
      .o_fault_n(fault_n), .o_clip_temp_warning_n(warn_n), .o_ramp_active(ramp),
      .o_bridge(br));
   // ==========================================================
   // shared steps
   task automatic settle();
      repeat (5) @(negedge clk);
   endtask
   task automatic look(input string nm, input logic f, input logic w, input logic h0,
         input logic h3);
      `CHK({nm, " fault_n"}, f, fault_n)
      `CHK({nm, " warn_n"}, w, warn_n)
      `CHK({nm, " hiz0"}, h0, br[0].hiz)
      `CHK({nm, " hiz3"}, h3, br[CH-1].hiz)
      $display("test %s done", nm);
   endtask
   // reset pin pulse through the controller, checking ramp-down and pull-downs
   task automatic reset_cycle(input logic hiz_in_ramp);
      run <= 1'b0;
      repeat (6) @(negedge clk);
      `CHK("ramp", 1'b1, ramp)
      `CHK("ramp hiz", hiz_in_ramp, br[0].hiz)
      `CHK("fault forced", 1'b1, fault_n)
      `CHK("pull", !bridge_tied_mode, br[0].pull_down)
      `CHK("weak pull", bridge_tied_mode, br[0].weak_pull_down)
      repeat (RAMP + 4) @(negedge clk);
      `CHK("ramp end", 1'b0, ramp)
      `CHK("held hiz", 1'b1, br[0].hiz)
      run <= 1'b1;
      repeat (100) if (rst_n !== 1'b1) @(negedge clk);
      settle();
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #(8 * 20000);
      bad_count++;
      results();
   end
   // ==========================================================
   // tests
   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (100) if (rst_n !== 1'b1) @(negedge clk);
      settle();
      look("normal", 1'b1, 1'b1, 1'b0, 1'b0);
      det.temp_warning = 1'b1;
      settle();
      `CHK("warn switching", 1'b1, br[0].switch_en)
      look("warning", 1'b1, 1'b0, 1'b0, 1'b0);
      det.temp_warning = 1'b0;
      settle();
      look("warn clear", 1'b1, 1'b1, 1'b0, 1'b0);
      ce = 1'b0;
      det.temp_warning = 1'b1;
      settle();
      `CHK("frozen warn", 1'b1, warn_n)
      det.temp_warning = 1'b0;
      ce = 1'b1;
      settle();
      for (int k = 1; k <= 4; k++) begin
         det = afp_global_s'(7'h1 << k);
         settle();
         look("supply fault", 1'b0, 1'b1, 1'b1, 1'b1);
         det = '0;
         settle();
         look("supply back", 1'b1, 1'b1, 1'b0, 1'b0);
      end
      bst[2] = 1'b1;
      settle();
      `CHK("boot high side", 1'b0, br[2].high_side_en)
      `CHK("boot other", 1'b1, br[0].high_side_en)
      look("bootstrap", 1'b1, 1'b1, 1'b0, 1'b0);
      bst[2] = 1'b0;
      det.clock_lost = 1'b1;
      settle();
      look("clock master", 1'b1, 1'b1, 1'b0, 1'b0);
      slave = 1'b1;
      settle();
      look("clock lost", 1'b1, 1'b1, 1'b1, 1'b1);
      det.clock_lost = 1'b0;
      settle();
      look("clock back", 1'b1, 1'b1, 1'b0, 1'b0);
      det.temp_shutdown = 1'b1;
      settle();
      det.temp_shutdown = 1'b0;
      settle();
      look("shutdown latched", 1'b0, 1'b1, 1'b1, 1'b1);
      reset_cycle(1'b0);
      look("shutdown cleared", 1'b1, 1'b1, 1'b0, 1'b0);
      lim[2] = 1'b1;
      repeat (LIM + 10) @(negedge clk);
      lim[2] = 1'b0;
      settle();
      `CHK("overload ch", 1'b1, br[2].hiz)
      look("overload", 1'b0, 1'b1, 1'b0, 1'b0);
      bridge_tied_mode = 1'b0;
      reset_cycle(1'b0);
      `CHK("overload clr", 1'b0, br[2].hiz)
      look("overload cleared", 1'b1, 1'b1, 1'b0, 1'b0);
      results();
   end
endmodule // testbench
`default_nettype wire
